// >>> src/cap_sense_control.sv
// Capacitive sensing control: APB registers, oscillator and timer clocks.
// Assumes pclk at 20 MHz, an analog oscillator pulse on osc_in, and
// timer logic that samples the clock enables it is given.
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/100ps
module cap_sense_control #(
  parameter int NUM_INPUTS = cap_sense_pkg::NUM_INPUTS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Oscillator side
  input wire logic osc_in,
  input wire logic osc_dir_in,
  input wire logic timer0_ext_clock_pin,
  output logic [1:0] osc_current_range,
  output logic osc_run,
  output logic [11:0] sense_input_pin,
  // Timer clock enables
  output logic timer0_tick,
  output logic timer1_tick
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic sense_module_enable_r;
  logic [1:0] osc_current_range_r;
  logic timer0_ext_clock_select_r;
  logic [3:0] sense_channel_code_r;
  logic timer0_clock_source_select_r;
  logic [1:0] timer1_clock_source_field_r;
  logic sleep_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic osc_run_r;
  logic [1:0] range_out_r;
  logic [11:0] pin_r;
  logic t0_tick_r;
  logic t1_tick_r;
  logic [1:0] prescale_r;

  // Synchronisers: three stages, change counted when 2 and 3 agree
  logic [2:0] osc_sync_r;
  logic [2:0] dir_sync_r;
  logic [2:0] pin_sync_r;
  logic osc_lvl_r;
  logic dir_lvl_r;
  logic pin_lvl_r;

  logic wr_en;
  logic rd_en;
  logic osc_rise;
  logic pin_rise;

  cap_sense_mux_if mux ();

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == cap_sense_pkg::ADDR_CONTROL) ||
                 (a == cap_sense_pkg::ADDR_CHANNEL) ||
                 (a == cap_sense_pkg::ADDR_TIMER_CFG) ||
                 (a == cap_sense_pkg::ADDR_POWER);
  endfunction : addr_known

  // Access ends in the cycle pready is high
  assign wr_en = psel && penable && pwrite && pready_r;
  assign rd_en = psel && !penable && !pwrite;

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_module_enable_r <= 1'b0;
      osc_current_range_r <= 2'h0;
      timer0_ext_clock_select_r <= 1'b0;
    end else if (clk_en && wr_en &&
                 paddr == cap_sense_pkg::ADDR_CONTROL) begin
      // Bits 6:4 and 1 have no storage
      sense_module_enable_r <=
        pwdata[cap_sense_pkg::BIT_ENABLE];
      osc_current_range_r <=
        pwdata[cap_sense_pkg::RANGE_HI:cap_sense_pkg::RANGE_LO];
      timer0_ext_clock_select_r <= pwdata[cap_sense_pkg::BIT_T0_EXT_SEL];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_channel_code_r <= 4'h0;
    end else if (clk_en && wr_en &&
                 paddr == cap_sense_pkg::ADDR_CHANNEL) begin
      // Reserved codes are stored; the router selects nothing for them
      sense_channel_code_r <=
        pwdata[cap_sense_pkg::CHAN_HI:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer0_clock_source_select_r <= 1'b0;
      timer1_clock_source_field_r <= 2'h0;
    end else if (clk_en && wr_en &&
                 paddr == cap_sense_pkg::ADDR_TIMER_CFG) begin
      timer0_clock_source_select_r <= pwdata[cap_sense_pkg::BIT_T0_SRC];
      timer1_clock_source_field_r <=
        pwdata[cap_sense_pkg::T1_SRC_HI:cap_sense_pkg::T1_SRC_LO];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_r <= 1'b0;
    end else if (clk_en && wr_en &&
                 paddr == cap_sense_pkg::ADDR_POWER) begin
      sleep_r <= pwdata[cap_sense_pkg::BIT_SLEEP];
    end
  end

  // ---------------------------------------------------------------
  // APB answer: no wait states, read data latched in setup
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (clk_en) begin
      pready_r <= psel && !penable;
      pslverr_r <= psel && !penable && !addr_known(paddr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
    end else if (clk_en && rd_en) begin
      prdata_r <= 32'h0;
      unique case (paddr)
        cap_sense_pkg::ADDR_CONTROL: begin
          // Unused bits stay zero
          prdata_r[cap_sense_pkg::BIT_ENABLE] <=
            sense_module_enable_r;
          prdata_r[cap_sense_pkg::RANGE_HI:cap_sense_pkg::RANGE_LO] <=
            osc_current_range_r;
          prdata_r[cap_sense_pkg::BIT_DIRECTION] <= dir_lvl_r;
          prdata_r[cap_sense_pkg::BIT_T0_EXT_SEL] <=
            timer0_ext_clock_select_r;
        end
        cap_sense_pkg::ADDR_CHANNEL: begin
          prdata_r[cap_sense_pkg::CHAN_HI:0] <= sense_channel_code_r;
        end
        cap_sense_pkg::ADDR_TIMER_CFG: begin
          prdata_r[cap_sense_pkg::BIT_T0_SRC] <= timer0_clock_source_select_r;
          prdata_r[cap_sense_pkg::T1_SRC_HI:cap_sense_pkg::T1_SRC_LO] <=
            timer1_clock_source_field_r;
        end
        cap_sense_pkg::ADDR_POWER: begin
          prdata_r[cap_sense_pkg::BIT_SLEEP] <= sleep_r;
        end
        default: begin
          prdata_r <= 32'h0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_sync_r <= 3'h0;
      dir_sync_r <= 3'h0;
      pin_sync_r <= 3'h0;
    end else if (clk_en) begin
      osc_sync_r <= {osc_sync_r[1:0], osc_in};
      dir_sync_r <= {dir_sync_r[1:0], osc_dir_in};
      pin_sync_r <= {pin_sync_r[1:0], timer0_ext_clock_pin};
    end
  end

  // Filtered levels move only when the last two stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_lvl_r <= 1'b0;
      dir_lvl_r <= 1'b0;
      pin_lvl_r <= 1'b0;
    end else if (clk_en) begin
      if (osc_sync_r[1] == osc_sync_r[2]) begin
        osc_lvl_r <= osc_sync_r[2];
      end
      if (dir_sync_r[1] == dir_sync_r[2]) begin
        dir_lvl_r <= dir_sync_r[2];
      end
      if (pin_sync_r[1] == pin_sync_r[2]) begin
        pin_lvl_r <= pin_sync_r[2];
      end
    end
  end

  assign osc_rise = (osc_sync_r[1] == osc_sync_r[2]) &&
                    osc_sync_r[2] && !osc_lvl_r;
  assign pin_rise = (pin_sync_r[1] == pin_sync_r[2]) &&
                    pin_sync_r[2] && !pin_lvl_r;

  // ---------------------------------------------------------------
  // Oscillator control
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_run_r <= 1'b0;
      range_out_r <= 2'h0;
    end else if (clk_en) begin
      // Sleep does not stop it
      osc_run_r <= sense_module_enable_r &&
        (osc_current_range_r !=
         cap_sense_pkg::RANGE_OFF);
      range_out_r <= sense_module_enable_r ?
        osc_current_range_r : cap_sense_pkg::RANGE_OFF;
    end
  end

  // ---------------------------------------------------------------
  // Channel routing
  // ---------------------------------------------------------------
  assign mux.enable = sense_module_enable_r;
  assign mux.channel = sense_channel_code_r;

  cap_sense_router #(
    .NUM_INPUTS(NUM_INPUTS)
  ) u_router (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .mux(mux.router)
  );

  // Oscillator onto the chosen pad only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_r <= 12'h0;
    end else if (clk_en) begin
      pin_r <= osc_run_r ? mux.select : 12'h0;
    end
  end

  // ---------------------------------------------------------------
  // Timer clock selection
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_r <= 2'h0;
    end else if (clk_en) begin
      prescale_r <= prescale_r + 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t0_tick_r <= 1'b0;
    end else if (clk_en) begin
      if (sleep_r) begin
        t0_tick_r <= 1'b0;
      end else if (!timer0_clock_source_select_r) begin
        // Ext select ignored here
        t0_tick_r <= (prescale_r ==
          2'(cap_sense_pkg::PRESCALE_DIV - 1));
      end else if (timer0_ext_clock_select_r) begin
        t0_tick_r <= osc_rise && osc_run_r;
      end else begin
        t0_tick_r <= pin_rise;
      end
    end
  end

  // Timer1 keeps counting in sleep; other sources live in the timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t1_tick_r <= 1'b0;
    end else if (clk_en) begin
      t1_tick_r <= (timer1_clock_source_field_r ==
        cap_sense_pkg::T1_SRC_SENSE) && osc_rise && osc_run_r;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign osc_current_range = range_out_r;
  assign osc_run = osc_run_r;
  assign sense_input_pin = pin_r;
  assign timer0_tick = t0_tick_r;
  assign timer1_tick = t1_tick_r;

endmodule : cap_sense_control

// >>> src/cap_sense_pkg.sv
// Constants shared by the capacitive sensing control block.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package cap_sense_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_CHANNEL = 8'h04;
  localparam logic [7:0] ADDR_TIMER_CFG = 8'h08;
  localparam logic [7:0] ADDR_POWER = 8'h0c;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_ENABLE = 7;
  localparam int RANGE_HI = 3;
  localparam int RANGE_LO = 2;
  localparam int BIT_DIRECTION = 1;
  localparam int BIT_T0_EXT_SEL = 0;
  localparam int CHAN_HI = 3;
  localparam int BIT_T0_SRC = 0;
  localparam int T1_SRC_HI = 2;
  localparam int T1_SRC_LO = 1;
  localparam int BIT_SLEEP = 0;

  // ---------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CHANNEL_RESET = 8'h00;
  localparam logic [3:0] CHAN_LAST = 4'hb;
  localparam logic [1:0] T1_SRC_SENSE = 2'h3;
  localparam int NUM_INPUTS = 12;
  localparam int PRESCALE_DIV = 4;

  typedef enum logic [1:0] {
    RANGE_OFF = 2'b00,
    RANGE_LOW = 2'b01,
    RANGE_MED = 2'b10,
    RANGE_HIGH = 2'b11
  } osc_range_e;

endpackage : cap_sense_pkg

// >>> src/cap_sense_mux_if.sv
// Carrier between the register block and the channel router.
// Assumes both ends share pclk.
`timescale 1ns/100ps
interface cap_sense_mux_if;
  logic enable;
  logic [3:0] channel;
  logic [11:0] select;

  modport ctrl (output enable, output channel, input select);
  modport router (input enable, input channel, output select);
endinterface : cap_sense_mux_if

// >>> src/cap_sense_router.sv
// Decodes channel code into a one-hot sense input select.
// Assumes enable and channel are already registered on pclk.
`timescale 1ns/100ps
module cap_sense_router #(
  parameter int NUM_INPUTS = 12
) (
  // Clocking
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Control side
  cap_sense_mux_if.router mux
);

  // ---------------------------------------------------------------
  // One-hot select register
  // ---------------------------------------------------------------
  logic [NUM_INPUTS-1:0] select_r;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_sel
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          select_r[gi] <= 1'b0;
        end else if (clk_en) begin
          // Reserved codes match nothing
          select_r[gi] <= mux.enable &&
            (mux.channel == 4'(gi));
        end
      end
    end
  endgenerate

  assign mux.select = select_r;

endmodule : cap_sense_router

// >>> sim/cap_sense_pad_model.sv
// Pad and oscillator model for the capacitive sensing block.
// Assumes the block's osc_run output gates the triangle oscillator.
`timescale 1ns/100ps
module cap_sense_pad_model #(
  parameter int OSC_HALF = 5,
  parameter int PIN_HALF = 7
) (
  // Clock
  input wire logic pclk,
  // From the block
  input wire logic osc_run,
  // To the block
  output logic osc_in,
  output logic osc_dir_in,
  output logic timer0_ext_clock_pin
);
  int oc = 0;
  int pc = 0;
  logic osc_r = 1'b0;
  logic ext_r = 1'b0;
  assign osc_in = osc_r;
  assign timer0_ext_clock_pin = ext_r;
  // Rising ramp means sourcing current
  assign osc_dir_in = osc_r;
  always @(posedge pclk) begin
    pc <= (pc == PIN_HALF - 1) ? 0 : pc + 1;
    if (pc == PIN_HALF - 1) begin
      ext_r <= !ext_r;
    end
    // Stands still while off, so stale edges cannot leak into counts
    if (osc_run !== 1'b1) begin
      oc <= 0;
      osc_r <= 1'b0;
    end else begin
      oc <= (oc == OSC_HALF - 1) ? 0 : oc + 1;
      if (oc == OSC_HALF - 1) begin
        osc_r <= !osc_r;
      end
    end
  end
endmodule : cap_sense_pad_model

// >>> sim/cap_sense_control_sva.sv
// Port checker for cap_sense_control.
// Assumes one pclk domain and a two-cycle APB access.
`timescale 1ns/100ps
module cap_sense_control_sva #(
  parameter int NUM_INPUTS = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Oscillator and timers
  input wire logic osc_run,
  input wire logic [1:0] osc_current_range,
  input wire logic [11:0] sense_input_pin,
  input wire logic timer0_tick,
  input wire logic timer1_tick
);
  default clocking cb @(posedge pclk); endclocking
  // Frozen cycles answer nothing, so they are left out
  default disable iff (!presetn || !clk_en);
  sequence setup_s; psel && !penable; endsequence
  sequence read_s; pready && !pwrite; endsequence
  ack_once_a: assert property (setup_s |=> pready ##1 !pready)
    else $error("access not answered once");
  bad_addr_a: assert property (pready |-> pslverr ==
    !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c}))
    else $error("error response wrong");
  ctrl_zero_a: assert property ((read_s and (paddr == 8'h00)) |->
    prdata[31:8] == 24'h0 && prdata[6:4] == 3'h0)
    else $error("control pad bits not zero");
  chan_zero_a: assert property ((read_s and (paddr == 8'h04)) |->
    prdata[31:4] == 28'h0) else $error("channel pad bits not zero");
  range_live_a: assert property (osc_run |-> osc_current_range != 2'b00)
    else $error("running with range off");
  route_onehot_a: assert property ($onehot0(sense_input_pin[NUM_INPUTS-1:0]))
    else $error("more than one input routed");
  route_idle_a: assert property ((!osc_run)[*3] |-> sense_input_pin == 12'h000)
    else $error("input routed while idle");
  t0_space_a: assert property (timer0_tick |=> (!timer0_tick)[*3])
    else $error("timer0 ticks too close");
  t1_idle_a: assert property ((!osc_run)[*8] |-> !timer1_tick)
    else $error("timer1 ticks with oscillator off");
endmodule : cap_sense_control_sva

bind cap_sense_control cap_sense_control_sva #(.NUM_INPUTS(NUM_INPUTS)) i_sva (
  .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .osc_run, .osc_current_range, .sense_input_pin, .timer0_tick,
  .timer1_tick);

// >>> sim/tb_top.sv
// Self-checking bench for cap_sense_control.
// Assumes the pad model on the oscillator side and a 20 MHz pclk.
`timescale 1ns/100ps
module tb_top;
  localparam int NO = 80 / (2 * 5);
  localparam int NP = 80 / (2 * 7);
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, err, osc_in, osc_dir_in, timer0_ext_clock_pin;
  logic osc_run, timer0_tick, timer1_tick;
  logic [1:0] osc_current_range;
  logic [11:0] sense_input_pin;
  int miscompares = 0;
  int comparisons = 0;
  int cyc = 0;
  typedef struct { logic [7:0] a; logic [31:0] d, m, e; } row_s;
  typedef struct { logic [31:0] c, t, s; int l0, h0, l1, h1; } tm_s;
  row_s rows[6] = '{'{8'h00, 32'hffffffff, 32'hfffffffd, 32'h8d},
    '{8'h04, 32'hfffffff5, 32'hffffffff, 32'h05},
    '{8'h08, 32'hffffffff, 32'hffffffff, 32'h07},
    '{8'h0c, 32'hfffffffe, 32'hffffffff, 32'h00},
    '{8'h10, 32'hffffffff, 32'hffffffff, 32'h00},
    '{8'h00, 32'h00000002, 32'hfffffffd, 32'h00}};
  tm_s tm[6] = '{'{32'h8d, 32'h0, 32'h0, 20, 20, 0, 0},
    '{32'h8d, 32'h7, 32'h0, NO - 1, NO + 1, NO - 1, NO + 1},
    '{32'h8c, 32'h1, 32'h0, NP, NP + 1, 0, 0},
    '{32'h81, 32'h7, 32'h0, 0, 0, 0, 0},
    '{32'h8d, 32'h6, 32'h1, 0, 0, NO - 1, NO + 1},
    '{32'h8d, 32'h7, 32'h1, 0, 0, NO - 1, NO + 1}};
  cap_sense_control i_cap_sense_control (.pclk, .presetn, .clk_en, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .osc_in,
    .osc_dir_in, .timer0_ext_clock_pin, .osc_current_range, .osc_run,
    .sense_input_pin, .timer0_tick, .timer1_tick);
  cap_sense_pad_model i_cap_sense_pad_model (.pclk, .osc_run, .osc_in,
    .osc_dir_in, .timer0_ext_clock_pin);
  always #25 pclk = ~pclk;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic win(input int v, input int lo, input int hi);
    chk(32'(v >= lo && v <= hi), 32'h1);
  endtask : win
  // Idle cycle after each transfer keeps strobes single-assigned
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No local limit; the bench timeout ends this wait if pready never rises
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic cnt(output int a, output int b);
    a = 0;
    b = 0;
    repeat (8) @(posedge pclk);
    repeat (80) begin
      @(posedge pclk);
      a += int'(timer0_tick === 1'b1);
      b += int'(timer1_tick === 1'b1);
    end
  endtask : cnt
  task automatic end_sim();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      end_sim();
    end
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    int a, b;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(q, 32'h0);
    end
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk(q & rows[i].m, rows[i].e);
      chk(32'(err), 32'(rows[i].a > 8'h0c));
    end
    foreach (tm[i]) begin
      apb(1'b1, 8'h00, tm[i].c);
      apb(1'b1, 8'h08, tm[i].t);
      apb(1'b1, 8'h0c, tm[i].s);
      cnt(a, b);
      win(a, tm[i].l0, tm[i].h0);
      win(b, tm[i].l1, tm[i].h1);
    end
    apb(1'b1, 8'h0c, 32'h0);
    $display("table tests done");
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, 8'h00, 32'h80 | 32'(r << 2));
      repeat (2) @(posedge pclk);
      chk(32'(osc_current_range), 32'(r));
      chk(32'(osc_run), 32'(r != 0));
    end
    for (int c = 0; c < 12; c++) begin
      apb(1'b1, 8'h04, 32'(c));
      repeat (3) @(posedge pclk);
      chk(32'(sense_input_pin), 32'(1) << c);
    end
    apb(1'b1, 8'h00, 32'h0c);
    repeat (3) @(posedge pclk);
    chk(32'(sense_input_pin), 32'h0);
    chk(32'(osc_current_range), 32'h0);
    chk(32'(osc_run), 32'h0);
    $display("routing test done");
    apb(1'b1, 8'h00, 32'h8c);
    a = 0;
    b = 0;
    repeat (12) begin
      apb(1'b0, 8'h00, 32'h0);
      a += int'(q[1] === 1'b1);
      b += int'(q[1] === 1'b0);
    end
    chk(32'(a > 0 && b > 0), 32'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0);
    // Frozen clock enable: a pending write must neither answer nor land
    clk_en <= 1'b0;
    psel <= 1'b1;
    pwrite <= 1'b1;
    paddr <= 8'h04;
    pwdata <= 32'h3;
    repeat (4) @(posedge pclk);
    chk(32'(pready), 32'h0);
    psel <= 1'b0;
    pwrite <= 1'b0;
    repeat (2) @(posedge pclk);
    clk_en <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h0);
    $display("direction and reset tests done");
    end_sim();
  end
endmodule : tb_top
